// *** include/csc_pkg.sv ***
package csc_pkg;
	// Register addresses within the 7-bit serial address field.
	localparam logic [6:0] ADDR_CRANK = 7'h0A;
	localparam logic [6:0] ADDR_RUN = 7'h0B;
	localparam logic [6:0] ADDR_AUTO = 7'h0C;
	localparam logic [6:0] ADDR_MISC = 7'h0D;
	localparam logic [6:0] ADDR_TACHO = 7'h0E;
	localparam logic [6:0] ADDR_STATUS = 7'h0F;
	localparam logic [7:0] RUN_RESET = 8'h50;
	localparam logic [7:0] CRANK_RESET = 8'h00;
	localparam logic [7:0] AUTO_RESET = 8'h21;
	localparam logic [7:0] MISC_RESET = 8'h00;
	localparam logic [7:0] TACHO_RESET = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam int MISC_AUTO = 7;
	localparam int MISC_DISABLE = 6;
	localparam int MISC_REF_LOW = 4;
	localparam int MISC_DEGLITCH = 3;
	localparam int MISC_INVERT = 1;
	localparam int THR_HI = 7;
	localparam int THR_LO = 4;
	localparam int BLK_HI = 3;
	localparam int BLK_LO = 0;
	localparam int MANT_HI = 7;
	localparam int MANT_LO = 4;
	localparam int EXP_HI = 3;
	localparam int EXP_LO = 0;
	localparam logic [3:0] THR_MAX = 4'hF;
	localparam int BLANK_SHIFT = 5;
	localparam int DEGL_MUL = 5;
	localparam int DEGL_SHIFT = 9;
	localparam int CLK_MHZ = 125;
	localparam int DECAY_UNIT_NS = 1000;
	localparam int DECAY_UNIT_CYC = (DECAY_UNIT_NS * CLK_MHZ) / 1000;
	localparam int SPI_BITS = 16;
	localparam int SPI_WR_BIT = 15;
	localparam int SPI_ADDR_HI = 14;
	localparam int SPI_ADDR_LO = 8;
	localparam int SPI_ADDR_DONE = 8;
	localparam int STS_CRANK = 0;
	localparam int STS_BLANK = 1;
	localparam int STS_OUT = 2;
endpackage

// *** rtl/csc_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module csc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] asyncIn,
	output var logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] s1Q;
	logic [WIDTH-1:0] s2Q;
	logic [WIDTH-1:0] s3Q;
	logic [WIDTH-1:0] outD;
	logic [WIDTH-1:0] outQ;

	// A change is taken once the second and third stages agree.
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : gBit
			always_comb begin
				outD[i] = (s2Q[i] == s3Q[i]) ? s3Q[i] : outQ[i];
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s1Q <= '0;
			s2Q <= '0;
			s3Q <= '0;
			outQ <= '0;
		end else begin
			s1Q <= asyncIn;
			s2Q <= s1Q;
			s3Q <= s2Q;
			outQ <= outD;
		end
	end

	assign syncOut = outQ;
endmodule
`default_nettype wire

// *** rtl/csc_spi_slave.sv ***
`timescale 1ns/100ps
`default_nettype none
module csc_spi_slave (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic sckIn,
	input wire logic csNIn,
	input wire logic mosiIn,
	input wire logic [7:0] rdData,
	output var logic [6:0] rdAddr,
	output var logic wrStrobe,
	output var logic [6:0] wrAddr,
	output var logic [7:0] wrData,
	output var logic misoOut,
	output var logic misoOe
);
	logic sckQ;
	logic [15:0] shD;
	logic [15:0] shQ;
	logic [4:0] cntD;
	logic [4:0] cntQ;
	logic [7:0] txD;
	logic [7:0] txQ;
	logic misoD;
	logic misoQ;
	logic wrD;
	logic wrQ;
	logic rise;
	logic fall;

	// Mode 0 frames: sample on rising clock, shift out on falling clock.
	always_comb begin
		rise = sckIn && !sckQ;
		fall = !sckIn && sckQ;
		shD = shQ;
		cntD = cntQ;
		txD = txQ;
		misoD = misoQ;
		wrD = 1'b0;
		if (csNIn) begin
			cntD = '0;
			misoD = 1'b0;
		end else if (rise) begin
			shD = {shQ[14:0], mosiIn};
			cntD = cntQ + 5'h01;
			if (cntQ == 5'(csc_pkg::SPI_ADDR_DONE - 1)) begin
				txD = rdData;
			end
			if (cntQ == 5'(csc_pkg::SPI_BITS - 1)) begin
				wrD = shQ[csc_pkg::SPI_WR_BIT - 1];
			end
		end else if (fall && cntQ >= 5'(csc_pkg::SPI_ADDR_DONE)) begin
			misoD = txQ[7];
			txD = {txQ[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sckQ <= 1'b0;
			shQ <= '0;
			cntQ <= '0;
			txQ <= '0;
			misoQ <= 1'b0;
			wrQ <= 1'b0;
		end else begin
			sckQ <= sckIn;
			shQ <= shD;
			cntQ <= cntD;
			txQ <= txD;
			misoQ <= misoD;
			wrQ <= wrD;
		end
	end

	// The last address bit is still on the data line when the read word is fetched.
	assign rdAddr = {shQ[5:0], mosiIn};
	assign wrStrobe = wrQ;
	assign wrAddr = shQ[csc_pkg::SPI_ADDR_HI:csc_pkg::SPI_ADDR_LO];
	assign wrData = shQ[7:0];
	assign misoOut = misoQ;
	assign misoOe = !csNIn;
endmodule
`default_nettype wire

// *** rtl/crank_sensor_conditioner.sv ***
`timescale 1ns/100ps
`default_nettype none
module crank_sensor_conditioner #(
	parameter int CNT_W = 24
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic sensorCompIn,
	input wire logic sensorZeroIn,
	input wire logic spiSck,
	input wire logic spiCsN,
	input wire logic spiMosi,
	output var logic spiMiso,
	output var logic spiMisoOe,
	output var logic [3:0] thresholdCode,
	output var logic conditionedPulseOut,
	output var logic tachoDriveOut
);
	// ==========================================================
	// Input synchronisers and serial port
	// ==========================================================
	logic [4:0] syncV;
	logic compS;
	logic zeroS;
	logic [6:0] rdAddr;
	logic [7:0] rdData;
	logic wrStb;
	logic [6:0] wrAddr;
	logic [7:0] wrData;

	csc_sync #(.WIDTH(5)) csc_sync_inst (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.asyncIn({spiSck, spiCsN, spiMosi, sensorCompIn, sensorZeroIn}),
		.syncOut(syncV)
	);

	csc_spi_slave csc_spi_slave_inst (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.sckIn(syncV[4]),
		.csNIn(syncV[3]),
		.mosiIn(syncV[2]),
		.rdData(rdData),
		.rdAddr(rdAddr),
		.wrStrobe(wrStb),
		.wrAddr(wrAddr),
		.wrData(wrData),
		.misoOut(spiMiso),
		.misoOe(spiMisoOe)
	);

	// ==========================================================
	// Parameter registers
	// ==========================================================
	logic [7:0] runD, runQ, crankD, crankQ, autoD, autoQ;
	logic [7:0] miscD, miscQ, tachoD, tachoQ;

	always_comb begin
		runD = runQ;
		crankD = crankQ;
		autoD = autoQ;
		miscD = miscQ;
		tachoD = tachoQ;
		if (wrStb) begin
			unique case (wrAddr)
				csc_pkg::ADDR_RUN: runD = wrData;
				csc_pkg::ADDR_CRANK: crankD = wrData;
				csc_pkg::ADDR_AUTO: autoD = wrData;
				csc_pkg::ADDR_MISC: miscD = wrData;
				csc_pkg::ADDR_TACHO: tachoD = wrData;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			runQ <= csc_pkg::RUN_RESET;
			crankQ <= csc_pkg::CRANK_RESET;
			autoQ <= csc_pkg::AUTO_RESET;
			miscQ <= csc_pkg::MISC_RESET;
			tachoQ <= csc_pkg::TACHO_RESET;
		end else begin
			runQ <= runD;
			crankQ <= crankD;
			autoQ <= autoD;
			miscQ <= miscD;
			tachoQ <= tachoD;
		end
	end

	// ==========================================================
	// Parameter set selection and pulse measurement
	// ==========================================================
	logic crankSel;
	logic [7:0] selSet;
	logic outQ, outD;
	logic blanking;
	logic [CNT_W-1:0] hiCntD, hiCntQ, loCntD, loCntQ;
	logic [CNT_W-1:0] hiLenD, hiLenQ, loLenD, loLenQ;
	logic [CNT_W-1:0] refLen;
	logic [CNT_W-1:0] deglLen;
	logic [CNT_W+3:0] blankProd;
	logic [CNT_W+2:0] deglProd;

	always_comb begin
		crankSel = crankQ != csc_pkg::ZERO_BYTE;
		selSet = crankSel ? crankQ : runQ;
		hiCntD = hiCntQ;
		loCntD = loCntQ;
		hiLenD = hiLenQ;
		loLenD = loLenQ;
		if (outQ) begin
			if (!(&hiCntQ)) begin
				hiCntD = hiCntQ + 1'b1;
			end
		end else if (!(&loCntQ)) begin
			loCntD = loCntQ + 1'b1;
		end
		if (outQ && !outD) begin
			hiLenD = hiCntQ;
			hiCntD = '0;
		end
		if (!outQ && outD) begin
			loLenD = loCntQ;
			loCntD = '0;
		end
		refLen = miscQ[csc_pkg::MISC_REF_LOW] ? loLenQ : hiLenQ;
		deglProd = (CNT_W+3)'(hiLenQ) * (CNT_W+3)'(csc_pkg::DEGL_MUL);
		deglLen = CNT_W'(deglProd >> csc_pkg::DEGL_SHIFT);
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			hiCntQ <= '0;
			loCntQ <= '0;
			hiLenQ <= '0;
			loLenQ <= '0;
		end else begin
			hiCntQ <= hiCntD;
			loCntQ <= loCntD;
			hiLenQ <= hiLenD;
			loLenQ <= loLenD;
		end
	end

	// ==========================================================
	// Deglitch filter
	// ==========================================================
	logic compIn;
	logic degD, degQ;
	logic [CNT_W-1:0] degCntD, degCntQ;

	always_comb begin
		compIn = compS ^ miscQ[csc_pkg::MISC_INVERT];
		degD = degQ;
		degCntD = '0;
		if (!miscQ[csc_pkg::MISC_DEGLITCH]) begin
			degD = compIn;
		end else if (compIn != degQ) begin
			// A level must hold for the whole window before it is taken.
			degCntD = degCntQ + 1'b1;
			if (degCntQ >= deglLen) begin
				degD = compIn;
				degCntD = '0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			degQ <= 1'b0;
			degCntQ <= '0;
		end else begin
			degQ <= degD;
			degCntQ <= degCntD;
		end
	end

	// ==========================================================
	// One-shot blanking and conditioned output
	// ==========================================================
	logic [3:0] blkCodeD, blkCodeQ, thrCodeD, thrCodeQ;
	logic [CNT_W-1:0] blkCntD, blkCntQ, blkLen;

	always_comb begin
		blankProd = (CNT_W+4)'(refLen) * (CNT_W+4)'(blkCodeQ);
		blkLen = CNT_W'(blankProd >> csc_pkg::BLANK_SHIFT);
		blanking = blkCntQ != '0;
		outD = outQ;
		blkCntD = blanking ? blkCntQ - 1'b1 : blkCntQ;
		blkCodeD = blkCodeQ;
		thrCodeD = thrCodeQ;
		// Codes are picked up only between pulses so a running blank is untouched.
		if (!outQ && !blanking) begin
			blkCodeD = selSet[csc_pkg::BLK_HI:csc_pkg::BLK_LO];
			thrCodeD = selSet[csc_pkg::THR_HI:csc_pkg::THR_LO];
		end
		if (miscQ[csc_pkg::MISC_DISABLE]) begin
			outD = 1'b0;
			blkCntD = '0;
		end else if (!blanking && degQ != outQ) begin
			outD = degQ;
			blkCntD = blkLen;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			outQ <= 1'b0;
			blkCntQ <= '0;
			blkCodeQ <= csc_pkg::RUN_RESET[csc_pkg::BLK_HI:csc_pkg::BLK_LO];
			thrCodeQ <= csc_pkg::RUN_RESET[csc_pkg::THR_HI:csc_pkg::THR_LO];
		end else begin
			outQ <= outD;
			blkCntQ <= blkCntD;
			blkCodeQ <= blkCodeD;
			thrCodeQ <= thrCodeD;
		end
	end

	// ==========================================================
	// Automatic threshold with decay
	// ==========================================================
	logic zeroQ;
	logic zeroEdge;
	logic [3:0] thrD, thrQ;
	logic [7:0] unitD, unitQ;
	logic [19:0] stepD, stepQ, stepLen;

	always_comb begin
		zeroEdge = zeroS && !zeroQ;
		stepLen = 20'({16'h0000, autoQ[csc_pkg::MANT_HI:csc_pkg::MANT_LO]} + 20'h00001)
			<< autoQ[csc_pkg::EXP_HI:csc_pkg::EXP_LO];
		unitD = unitQ + 8'h01;
		stepD = stepQ;
		thrD = thrQ;
		if (unitQ == 8'(csc_pkg::DECAY_UNIT_CYC - 1)) begin
			unitD = '0;
			stepD = stepQ + 20'h00001;
		end
		if (!miscQ[csc_pkg::MISC_AUTO]) begin
			thrD = thrCodeQ;
			stepD = '0;
		end else if (zeroEdge) begin
			thrD = csc_pkg::THR_MAX;
			stepD = '0;
		end else if (stepQ >= stepLen) begin
			stepD = '0;
			if (thrQ > thrCodeQ) begin
				thrD = thrQ - 4'h1;
			end else begin
				thrD = thrCodeQ;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			zeroQ <= 1'b0;
			thrQ <= csc_pkg::RUN_RESET[csc_pkg::THR_HI:csc_pkg::THR_LO];
			unitQ <= '0;
			stepQ <= '0;
		end else begin
			zeroQ <= zeroS;
			thrQ <= thrD;
			unitQ <= unitD;
			stepQ <= stepD;
		end
	end

	// ==========================================================
	// Tachometer divider
	// ==========================================================
	logic [7:0] tEdgeD, tEdgeQ;
	logic tachD, tachQ;

	always_comb begin
		tEdgeD = tEdgeQ;
		tachD = tachQ;
		if (tachoQ == csc_pkg::ZERO_BYTE) begin
			tachD = outQ;
			tEdgeD = '0;
		end else if (outD && !outQ) begin
			tEdgeD = tEdgeQ + 8'h01;
			if (tEdgeQ + 8'h01 >= tachoQ) begin
				tEdgeD = '0;
				tachD = !tachQ;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tEdgeQ <= '0;
			tachQ <= 1'b0;
		end else begin
			tEdgeQ <= tEdgeD;
			tachQ <= tachD;
		end
	end

	// ==========================================================
	// Read-back and outputs
	// ==========================================================
	always_comb begin
		compS = syncV[1];
		zeroS = syncV[0];
		unique case (rdAddr)
			csc_pkg::ADDR_RUN: rdData = runQ;
			csc_pkg::ADDR_CRANK: rdData = crankQ;
			csc_pkg::ADDR_AUTO: rdData = autoQ;
			csc_pkg::ADDR_MISC: rdData = miscQ;
			csc_pkg::ADDR_TACHO: rdData = tachoQ;
			csc_pkg::ADDR_STATUS: rdData = {thrQ, 1'b0, outQ, blanking, crankSel};
			default: rdData = csc_pkg::ZERO_BYTE;
		endcase
	end

	assign thresholdCode = thrQ;
	assign conditionedPulseOut = outQ;
	assign tachoDriveOut = tachQ;
endmodule
`default_nettype wire

// *** sim/csc_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
// =====
// Port checks.
module csc_asserts (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic sensorCompIn,
	input wire logic spiCsN,
	input wire logic spiMisoOe,
	input wire logic [3:0] thresholdCode,
	input wire logic conditionedPulseOut,
	input wire logic tachoDriveOut
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// Recent comparator history covers the synchroniser delay.
	logic [5:0] compHist_q;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			compHist_q <= 6'h00;
		end else begin
			compHist_q <= {compHist_q[4:0], sensorCompIn};
		end
	end
	property p_thr_rst;
		$rose(reset_n) |-> thresholdCode == 4'h5;
	endproperty
	a_thr_rst: assert property (p_thr_rst) else $error("threshold not at default");
	property p_rise;
		$rose(conditionedPulseOut) |-> |compHist_q[5:1];
	endproperty
	a_rise: assert property (p_rise) else $error("output rose without input");
	property p_fall;
		$fell(conditionedPulseOut) |-> !(&compHist_q[5:1]);
	endproperty
	a_fall: assert property (p_fall) else $error("output fell without input");
	property p_tacho_edge;
		$changed(tachoDriveOut) |-> $rose(conditionedPulseOut) || ($past(conditionedPulseOut) != $past(conditionedPulseOut, 2));
	endproperty
	a_tacho_edge: assert property (p_tacho_edge) else $error("tacho moved alone");
	property p_tacho_rise;
		$rose(tachoDriveOut) |-> conditionedPulseOut;
	endproperty
	a_tacho_rise: assert property (p_tacho_rise) else $error("tacho rose on low");
	property p_thr_hold;
		$changed(thresholdCode) |-> !$past(conditionedPulseOut, 2);
	endproperty
	a_thr_hold: assert property (p_thr_hold) else $error("threshold moved in pulse");
	property p_oe_on;
		$fell(spiCsN) |-> ##[2:6] spiMisoOe;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("miso enable late");
	property p_oe_off;
		$rose(spiCsN) |-> ##[2:6] !spiMisoOe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("miso enable stuck");
endmodule
bind crank_sensor_conditioner csc_asserts csc_asserts_inst (.clk_sys(clk_sys), .reset_n(reset_n),
	.sensorCompIn(sensorCompIn), .spiCsN(spiCsN), .spiMisoOe(spiMisoOe), .thresholdCode(thresholdCode),
	.conditionedPulseOut(conditionedPulseOut), .tachoDriveOut(tachoDriveOut));
`default_nettype wire

// *** sim/csc_sensor_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// =====
// Toothed wheel sensor with optional noise glitch after each tooth.
module csc_sensor_model (
	input wire logic clk_sys,
	input wire logic run,
	input wire logic [3:0] amp,
	input wire logic [3:0] thresholdCode,
	input wire logic [7:0] hiCyc,
	input wire logic [7:0] glitchAt,
	output var logic sensorCompIn,
	output var logic sensorZeroIn
);
	// The comparator fires only when the peak is above the threshold.
	logic above;
	assign above = amp > thresholdCode;
	initial begin
		sensorCompIn = 1'b0;
		sensorZeroIn = 1'b0;
		forever begin
			@(negedge clk_sys);
			if (run) begin
				sensorZeroIn = 1'b1;
				repeat (2) @(negedge clk_sys);
				sensorCompIn = above;
				repeat (hiCyc) @(negedge clk_sys);
				sensorCompIn = 1'b0;
				sensorZeroIn = 1'b0;
				if (glitchAt != 8'h00) begin
					repeat (glitchAt) @(negedge clk_sys);
					sensorCompIn = above;
					repeat (3) @(negedge clk_sys);
					sensorCompIn = 1'b0;
				end
				repeat (64) @(negedge clk_sys);
			end
		end
	end
endmodule
`default_nettype wire

// *** sim/crank_sensor_conditioner_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
// =====
// Register and pulse path tests.
module crank_sensor_conditioner_bench;
	logic clk_sys, reset_n, comp, zero, sck, csN, mosi, miso, misoOe, outP, tacho, run;
	logic [3:0] thr, amp;
	logic [7:0] hiCyc, glitchAt, rd;
	logic [3:0] blk [4] = '{4'hF, 4'h8, 4'h4, 4'h0};
	int numErrors, checksDone, nOut, nTacho;
	crank_sensor_conditioner crank_sensor_conditioner_inst (.clk_sys(clk_sys), .reset_n(reset_n),
		.sensorCompIn(comp), .sensorZeroIn(zero), .spiSck(sck), .spiCsN(csN), .spiMosi(mosi),
		.spiMiso(miso), .spiMisoOe(misoOe), .thresholdCode(thr), .conditionedPulseOut(outP),
		.tachoDriveOut(tacho));
	csc_sensor_model csc_sensor_model_inst (.clk_sys(clk_sys), .run(run), .amp(amp), .thresholdCode(thr),
		.hiCyc(hiCyc), .glitchAt(glitchAt), .sensorCompIn(comp), .sensorZeroIn(zero));
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge outP) nOut++;
	always @(posedge tacho) nTacho++;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checksDone++;
		if (seen !== exp) begin
			numErrors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// Mode 0 frame, each serial clock phase held eight system clocks.
	task automatic spi(input logic [15:0] f);
		csN = 1'b0;
		tick(8);
		for (int i = 15; i >= 0; i--) begin
			mosi = f[i];
			tick(8);
			if (i < 8) rd[i] = miso;
			sck = 1'b1;
			tick(8);
			sck = 1'b0;
		end
		tick(8);
		csN = 1'b1;
		tick(16);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		spi({1'b1, a, d});
	endtask
	task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
		spi({1'b0, a, 8'h00});
		check(rd, e);
	endtask
	// One sensor tooth per loop pass, n teeth per call, each with a quiet gap after it.
	task automatic pulses(input int n);
		nOut = 0;
		nTacho = 0;
		repeat (n) begin
			run <= 1'b1;
			tick(1);
			run <= 1'b0;
			tick(250);
		end
	endtask
	task automatic endSim;
		$display("errors %0d checks %0d", numErrors, checksDone);
		if (numErrors == 0 && checksDone > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk_sys);
		numErrors++;
		endSim();
	end
	initial begin
		reset_n = 1'b0;
		sck = 1'b0;
		csN = 1'b1;
		mosi = 1'b0;
		run = 1'b0;
		amp = 4'h6;
		hiCyc = 8'h40;
		glitchAt = 8'h00;
		numErrors = 0;
		checksDone = 0;
		tick(6);
		reset_n = 1'b1;
		tick(12);
		check({4'h0, thr}, 8'h05);
		rdchk(csc_pkg::ADDR_RUN, csc_pkg::RUN_RESET);
		rdchk(csc_pkg::ADDR_CRANK, csc_pkg::CRANK_RESET);
		rdchk(7'h10, 8'h00);
		pulses(4);
		check(nOut[7:0], 8'h04);
		check(nTacho[7:0], 8'h04);
		for (int c = 0; c < 16; c++) begin
			wr(csc_pkg::ADDR_RUN, {c[3:0], 4'h0});
			check({4'h0, thr}, {4'h0, c[3:0]});
			pulses(1);
			check(nOut[7:0], {7'h00, amp > c[3:0]});
		end
		wr(csc_pkg::ADDR_RUN, csc_pkg::RUN_RESET);
		wr(csc_pkg::ADDR_CRANK, 8'h73);
		check({4'h0, thr}, 8'h07);
		rdchk(csc_pkg::ADDR_STATUS, 8'h71);
		rdchk(csc_pkg::ADDR_RUN, csc_pkg::RUN_RESET);
		pulses(2);
		check(nOut[7:0], 8'h00);
		wr(csc_pkg::ADDR_CRANK, 8'h00);
		check({4'h0, thr}, 8'h05);
		glitchAt = 8'h0A;
		for (int k = 0; k < 4; k++) begin
			wr(csc_pkg::ADDR_RUN, {4'h5, blk[k]});
			pulses(3);
			check(nOut[7:0], ((int'(hiCyc) * blk[k]) >> 5) < glitchAt ? 8'h06 : 8'h03);
		end
		// Low-pulse reference makes code 4 long enough to hide the glitch.
		wr(csc_pkg::ADDR_MISC, 8'h10);
		wr(csc_pkg::ADDR_RUN, 8'h54);
		pulses(3);
		check(nOut[7:0], 8'h03);
		wr(csc_pkg::ADDR_MISC, csc_pkg::MISC_RESET);
		glitchAt = 8'h00;
		wr(csc_pkg::ADDR_RUN, csc_pkg::RUN_RESET);
		wr(csc_pkg::ADDR_TACHO, 8'h01);
		rdchk(csc_pkg::ADDR_TACHO, 8'h01);
		pulses(4);
		check(nTacho[7:0], 8'h02);
		wr(csc_pkg::ADDR_TACHO, 8'h00);
		wr(csc_pkg::ADDR_MISC, 8'h08);
		pulses(2);
		check(nOut[7:0], 8'h02);
		wr(csc_pkg::ADDR_MISC, 8'h40);
		pulses(2);
		check(nOut[7:0], 8'h00);
		// Automatic mode jumps to the top code on a zero crossing, then decays back.
		wr(csc_pkg::ADDR_MISC, 8'h80);
		pulses(1);
		check({4'h0, thr}, {4'h0, csc_pkg::THR_MAX});
		tick(8000);
		check({4'h0, thr}, 8'h05);
		wr(csc_pkg::ADDR_MISC, csc_pkg::MISC_RESET);
		endSim();
	end
endmodule
`default_nettype wire
